// >>> shared/rem_defines.svh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef REM_DEFINES_SVH
`define REM_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define REM_OFS_RESULT   8'h00
`define REM_OFS_CONTROL  8'h04
`define REM_OFS_IRQ_STAT 8'h08
`define REM_OFS_IRQ_EN   8'h0C
`define REM_OFS_IRQ_CLR  8'h10

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define REM_RES_DONE_BIT    7
`define REM_CTL_CIRCUIT_BIT 0
`define REM_CTL_START_BIT   1
`define REM_RESULT_RESET    8'h00
`define REM_CONTROL_RESET   2'h0
`define REM_IRQ_RESET       2'h0
`define REM_IRQ_DONE_BIT    0
`define REM_IRQ_SAT_BIT     1

// ****************************************************************
// Timing
// ****************************************************************
`define REM_SYNC_STAGES 2

`endif

// >>> shared/rem_pkg.sv
// Types shared by the efficiency measurement block.
package rem_pkg;

  typedef enum logic [1:0] {
    REM_IDLE,
    REM_ARMED,
    REM_COUNT,
    REM_DONE
  } rem_state_t;

endpackage : rem_pkg

// >>> core/rem_sync.sv
// Two-stage synchroniser for one asynchronous level.
`timescale 1ns/100ps
module rem_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Level in and out
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : rem_sync

// >>> core/rem_counter.sv
// Saturating up-counter used to count on-time clock cycles.
`timescale 1ns/100ps
module rem_counter #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic             clear_i,
  input  wire logic             count_i,
  // Result
  output logic [WIDTH-1:0]      value_o,
  output logic                  saturated_o
);

  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("rem_counter: WIDTH out of range");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      value_o <= '0;
    end else if (count_i && !saturated_o) begin
      value_o <= value_o + 1'b1;
    end
  end

  assign saturated_o = &value_o;

endmodule : rem_counter

// >>> core/rem_measure.sv
// Relative efficiency measurement: on-time counter with Wishbone registers.
`timescale 1ns/100ps
`include "rem_defines.svh"
module rem_measure
  import rem_pkg::*;
#(
  parameter int COUNT_W = 7
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // High-side gate pulse from the power stage
  input  wire logic        hs_on_i,
  // Analog block controls
  output logic             circuit_en_o,
  output logic             measure_start_o,
  // Interrupt
  output logic             irq_o
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // The result register holds exactly seven count bits below the done
  // flag, so any other width is refused while the design is built.
  if (COUNT_W != 7) begin : g_bad_width
    $error("rem_measure: result field is seven bits wide");
  end

  // ****************************************************************
  // Registers and signals
  // ****************************************************************
  rem_state_t         state_q;
  rem_state_t         state_d;
  logic               circuit_en_q;
  logic               start_q;
  logic               done_q;
  logic               done_d;
  logic [1:0]         irq_stat_q;
  logic [1:0]         irq_en_q;
  logic [1:0]         irq_set;
  logic [1:0]         irq_clr;
  logic               hs_on_s;
  logic               hs_on_prev_q;
  logic               hs_rise;
  logic               hs_fall;
  logic               cnt_first;
  logic               cnt_clear;
  logic               cnt_run;
  logic [COUNT_W-1:0] whole_count;
  logic               cnt_sat;
  logic               sat_prev_q;
  logic               bus_req;
  logic               wr_req;
  logic               wr_ctrl;
  logic               wr_irq_en;
  logic               wr_irq_clr;
  logic               mapped;
  logic [31:0]        rd_data;

  // ****************************************************************
  // Pin synchroniser and edge detection
  // ****************************************************************
  rem_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (hs_on_i),
    .sync_o  (hs_on_s)
  );

  // The previous sample resets low, the idle level of the pin, so no
  // false rise follows reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_on_prev_q <= 1'b0;
    end else begin
      hs_on_prev_q <= hs_on_s;
    end
  end

  assign hs_rise = hs_on_s && !hs_on_prev_q;
  assign hs_fall = !hs_on_s && hs_on_prev_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // A request is taken only while no answer stands, so a master that
  // holds its strobe is not served again in the cycle of its answer.
  assign bus_req    = cyc_i && stb_i && !ack_o && !err_o;
  assign wr_req     = bus_req && we_i && sel_i[0];
  assign wr_ctrl    = wr_req && (adr_i == `REM_OFS_CONTROL);
  assign wr_irq_en  = wr_req && (adr_i == `REM_OFS_IRQ_EN);
  assign wr_irq_clr = wr_req && (adr_i == `REM_OFS_IRQ_CLR);

  always_comb begin
    mapped  = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (adr_i)
      `REM_OFS_RESULT: begin
        rd_data[`REM_RES_DONE_BIT] = done_q;
        rd_data[COUNT_W-1:0]       = whole_count;
      end
      `REM_OFS_CONTROL: begin
        rd_data[`REM_CTL_CIRCUIT_BIT] = circuit_en_q;
        rd_data[`REM_CTL_START_BIT]   = start_q;
      end
      `REM_OFS_IRQ_STAT: begin
        rd_data[1:0] = irq_stat_q;
      end
      `REM_OFS_IRQ_EN: begin
        rd_data[1:0] = irq_en_q;
      end
      `REM_OFS_IRQ_CLR: begin
        rd_data = 32'h0000_0000;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Every request taken is answered exactly one cycle later, and the
  // request guard keeps the answer to a single cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= bus_req && mapped;
      err_o <= bus_req && !mapped;
    end
  end

  // Read data stands only alongside a read acknowledge and is zero
  // otherwise, so stale register contents never linger on the bus.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && mapped && !we_i) begin
      dat_o <= rd_data;
    end else begin
      dat_o <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      circuit_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      circuit_en_q <= dat_i[`REM_CTL_CIRCUIT_BIT];
    end
  end

  // The start bit is cleared along with the enable, since no cycle can
  // run on unpowered circuitry.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
    end else if (wr_ctrl) begin
      start_q <= dat_i[`REM_CTL_START_BIT] &&
                 dat_i[`REM_CTL_CIRCUIT_BIT];
    end
  end

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  // Armed waits for a fresh rising edge so a pulse already in progress
  // at start is never measured short. Dropping either control bit
  // abandons the cycle from any state.
  always_comb begin
    state_d = state_q;
    if (!circuit_en_q || !start_q) begin
      state_d = REM_IDLE;
    end else begin
      unique case (state_q)
        REM_IDLE: begin
          state_d = REM_ARMED;
        end
        REM_ARMED: begin
          if (hs_rise) begin
            state_d = REM_COUNT;
          end
        end
        REM_COUNT: begin
          if (hs_fall) begin
            state_d = REM_DONE;
          end
        end
        REM_DONE: begin
          state_d = REM_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= REM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The rise is found in the cycle of the first high sample, while the
  // sequencer is still armed, so that cycle counts as well; otherwise every
  // result would come out one clock short.
  assign cnt_first = (state_q == REM_ARMED) && hs_rise;
  assign cnt_clear = (state_q == REM_IDLE);
  assign cnt_run   = ((state_q == REM_COUNT) && hs_on_s) ||
                     cnt_first;

  // Counting stops at all ones, so an overlong pulse reads as the
  // largest value instead of wrapping to a short one.
  rem_counter #(
    .WIDTH (COUNT_W)
  ) u_counter (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .clear_i     (cnt_clear),
    .count_i     (cnt_run),
    .value_o     (whole_count),
    .saturated_o (cnt_sat)
  );

  // ****************************************************************
  // Done flag
  // ****************************************************************
  // Done rises with the falling edge that ends the counted pulse and
  // falls by itself once the start or enable bit is dropped.
  always_comb begin
    done_d = 1'b0;
    if (state_q == REM_COUNT && hs_fall) begin
      done_d = 1'b1;
    end else if (state_q == REM_DONE && circuit_en_q && start_q) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sat_prev_q <= 1'b0;
    end else begin
      sat_prev_q <= cnt_sat;
    end
  end

  assign irq_set[`REM_IRQ_DONE_BIT] = (state_q == REM_COUNT) && hs_fall;
  assign irq_set[`REM_IRQ_SAT_BIT]  = cnt_sat && !sat_prev_q;

  assign irq_clr = wr_irq_clr ? dat_i[1:0] : 2'b00;

  // One sticky flag per event. A set in the same cycle as a clear wins,
  // so an event is never lost to a late acknowledge.
  for (genvar b = 0; b < 2; b++) begin : g_irq_flag
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        irq_stat_q[b] <= 1'b0;
      end else if (irq_set[b]) begin
        irq_stat_q[b] <= 1'b1;
      end else if (irq_clr[b]) begin
        irq_stat_q[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_q <= `REM_IRQ_RESET;
    end else if (wr_irq_en) begin
      irq_en_q <= dat_i[1:0];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The interrupt line follows the status one cycle late and stays high
  // while any enabled event flag is set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      circuit_en_o <= 1'b0;
    end else begin
      circuit_en_o <= circuit_en_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      measure_start_o <= 1'b0;
    end else begin
      measure_start_o <= start_q;
    end
  end

endmodule : rem_measure

// >>> dv/rem_measure_props.sv
// Concurrent checks on the ports of the efficiency measurement block.
`timescale 1ns/100ps
`include "rem_defines.svh"
module rem_measure_props #(
  parameter int COUNT_W = 7
) (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  // Measurement and interrupt
  input wire logic        hs_on_i,
  input wire logic        circuit_en_o,
  input wire logic        measure_start_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence s_rd_res;
    ack_o && !we_i && adr_i == `REM_OFS_RESULT;
  endsequence
  a_ack_resp: assert property (s_req |=> ack_o ^ err_o)
    else $error("request not answered in one cycle");
  a_no_spur_ack: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o)
    else $error("answer without a request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_err_pulse: assert property (err_o |=> !err_o)
    else $error("err longer than one cycle");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
    else $error("unused read bits not zero");
  a_start_en: assert property (measure_start_o |-> circuit_en_o)
    else $error("start active without circuit enable");
  a_done_start: assert property (
    s_rd_res ##0 dat_o[7] |-> $past(measure_start_o, 4))
    else $error("done seen without a running cycle");
  a_done_clear: assert property (
    (!measure_start_o) [*5] ##0 s_rd_res |-> dat_o[7:0] == 8'h00)
    else $error("result not cleared while idle");
endmodule : rem_measure_props

bind rem_measure rem_measure_props #(.COUNT_W(COUNT_W)) rem_measure_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .hs_on_i(hs_on_i), .circuit_en_o(circuit_en_o),
  .measure_start_o(measure_start_o), .irq_o(irq_o));

// >>> dv/tb_top.sv
// Self-checking bench for the efficiency measurement block.
`timescale 1ns/100ps
`include "rem_defines.svh"
module tb_top;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, hs_on_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o;
  logic        ack_o, err_o, circuit_en_o, measure_start_o, irq_o;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          miscompares, tests_run, cycles, n;
  int          seed = 32'h1874_ac75;

  rem_measure #(.COUNT_W(7)) rem_measure_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .hs_on_i(hs_on_i), .circuit_en_o(circuit_en_o),
    .measure_start_o(measure_start_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task chk_dat(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk_dat

  task chk_bit(input string nm, input logic x, input logic g);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", nm, x, g);
    end
  endtask : chk_bit

  task print_verdict;
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict;
    end
  end

  // Each bus answer consumes the oldest expectation; bit 33 asks for data.
  always @(posedge clk_i) begin
    if (ack_o || err_o) begin
      e = exp_q.pop_front();
      chk_bit("err", e[32], err_o);
      if (e[33]) chk_dat("rdata", e[31:0], dat_o);
    end
  end

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s, input logic [33:0] x);
    exp_q.push_back(x);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do @(posedge clk_i); while (!(ack_o || err_o));
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task rd(input logic [7:0] a, input logic [31:0] v);
    bus(1'b0, a, 32'h0, 4'hf, {2'b10, v});
  endtask : rd

  task wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 4'hf, 34'h0);
  endtask : wr

  task meas(input int w, input logic [6:0] cnt, input logic [1:0] st);
    wr(`REM_OFS_CONTROL, 32'h1);
    rd(`REM_OFS_RESULT, 32'h0);
    chk_bit("circuit_en", 1'b1, circuit_en_o);
    wr(`REM_OFS_CONTROL, 32'h3);
    chk_bit("measure_start", 1'b1, measure_start_o);
    hs_on_i <= 1'b1;
    repeat (w) @(posedge clk_i);
    hs_on_i <= 1'b0;
    while (!irq_o) @(posedge clk_i);
    rd(`REM_OFS_RESULT, {24'h00_0000, 1'b1, cnt});
    wr(`REM_OFS_IRQ_EN, 32'h0);
    rd(`REM_OFS_IRQ_STAT, {30'h0, st});
    chk_bit("irq", 1'b0, irq_o);
    wr(`REM_OFS_IRQ_EN, 32'h1);
    rd(`REM_OFS_IRQ_CLR, 32'h0);
    chk_bit("irq", 1'b1, irq_o);
    wr(`REM_OFS_IRQ_CLR, 32'h3);
    rd(`REM_OFS_IRQ_STAT, 32'h0);
    chk_bit("irq", 1'b0, irq_o);
    rd(`REM_OFS_RESULT, {24'h00_0000, 1'b1, cnt});
    wr(`REM_OFS_CONTROL, 32'h1);
    chk_bit("measure_start", 1'b0, measure_start_o);
    repeat (2) @(posedge clk_i);
    rd(`REM_OFS_RESULT, 32'h0);
  endtask : meas

  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, hs_on_i, adr_i, sel_i, dat_i} = '0;
    {miscompares, tests_run, cycles} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0);
    bus(1'b0, 8'h14, 32'h0, 4'hf, {2'b01, 32'h0});
    wr(`REM_OFS_RESULT, 32'hff);
    rd(`REM_OFS_RESULT, 32'h0);
    wr(`REM_OFS_CONTROL, 32'h2);
    rd(`REM_OFS_CONTROL, 32'h0);
    chk_bit("circuit_en", 1'b0, circuit_en_o);
    wr(`REM_OFS_CONTROL, 32'h1);
    bus(1'b1, `REM_OFS_CONTROL, 32'h3, 4'he, 34'h0);
    rd(`REM_OFS_CONTROL, 32'h1);
    wr(`REM_OFS_IRQ_EN, 32'h1);
    repeat (3) begin
      n = 3 + {$random(seed)} % 60;
      meas(n, 7'(n), 2'b01);
    end
    meas(126, 7'd126, 2'b01);
    meas(200, 7'd127, 2'b11);
    wr(`REM_OFS_CONTROL, 32'h3);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_bit("measure_start", 1'b0, measure_start_o);
    rd(`REM_OFS_CONTROL, 32'h0);
    rd(`REM_OFS_IRQ_EN, 32'h0);
    print_verdict;
  end
endmodule : tb_top
